// file: usmt_pkg.sv
/*
  Shared constants for the serial transceiver: register offsets, field positions,
  reset values, oversampling counts and the one-hot state codes.
  Assumes a byte-addressed register port with one 32-bit word per register.
*/
`default_nettype none
package usmt_pkg;
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_CTRL1 = 8'h0C;
  localparam logic [7:0] OFS_CTRL2 = 8'h10;
  localparam logic [7:0] OFS_CTRL3 = 8'h14;
  localparam logic [7:0] OFS_GUARD = 8'h18;
  // status field positions and reset value
  localparam int ST_PARITY = 0, ST_FRAMING = 1, ST_NOISE = 2, ST_OVERRUN = 3, ST_IDLE = 4;
  localparam int ST_RXFULL = 5, ST_TXDONE = 6, ST_TXEMPTY = 7, ST_BREAK = 8, ST_CTS = 9;
  localparam logic [9:0] STATUS_RESET = 10'h0C0;
  // control 1 field positions
  localparam int C1_SEND_BREAK = 0, C1_RECEIVER_ON = 2, C1_TRANSMITTER_ON = 3;
  localparam int C1_IDLE_IRQ = 4, C1_RX_IRQ = 5, C1_TXDONE_IRQ = 6, C1_TXEMPTY_IRQ = 7;
  localparam int C1_PARITY_IRQ = 8, C1_ODD_PARITY = 9, C1_PARITY_ON = 10;
  localparam int C1_NINE_BITS = 12, C1_ENABLE = 13;
  // control 2 field positions
  localparam int C2_BREAK_IRQ = 6, C2_LAST_BIT_CLK = 8, C2_CLK_PHASE = 9, C2_CLK_POL = 10;
  localparam int C2_SYNC_CLK_EN = 11, C2_STOP_LO = 12, C2_STOP_HI = 13, C2_LIN_EN = 14;
  // control 3 field positions
  localparam int C3_ERROR_IRQ = 0, C3_INFRARED = 1, C3_SINGLE_WIRE = 3, C3_SMARTCARD = 5;
  localparam int C3_DMA_RX = 6, C3_DMA_TX = 7, C3_CTS_EN = 9, C3_CTS_IRQ = 10;
  // guard/prescaler register fields
  localparam int GP_PRESC_LO = 0, GP_PRESC_HI = 4, GP_GUARD_LO = 8, GP_GUARD_HI = 15;
  // oversampling: sixteen ticks per bit
  localparam logic [16:0] ACC_STEP = 17'h00010;
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICK_MID = 6'h08;
  localparam logic [5:0] STOP_TK_1 = 6'h10;
  localparam logic [5:0] STOP_TK_HALF = 6'h08;
  localparam logic [5:0] STOP_TK_2 = 6'h20;
  localparam logic [5:0] STOP_TK_ONEHALF = 6'h18;
  localparam logic [3:0] WORD_8 = 4'h8;
  localparam logic [3:0] WORD_9 = 4'h9;
  localparam logic [3:0] IDLE_FRAME_8 = 4'hA;
  localparam logic [3:0] IDLE_FRAME_9 = 4'hB;
  typedef enum logic [6:0] {
    TXS_IDLE = 7'h01, TXS_PREAMBLE = 7'h02, TXS_BREAK = 7'h04, TXS_START = 7'h08,
    TXS_DATA = 7'h10, TXS_STOP = 7'h20, TXS_GUARD = 7'h40
  } usmt_txst_t;
  typedef enum logic [5:0] {
    RXS_IDLE = 6'h01, RXS_START = 6'h02, RXS_DATA = 6'h04, RXS_STOP = 6'h08,
    RXS_NACK = 6'h10, RXS_WAITHI = 6'h20
  } usmt_rxst_t;
endpackage : usmt_pkg
`default_nettype wire

// file: usmt_top.sv
/*
  Multimode serial transceiver: fractional baud generator, transmitter, receiver,
  synchronous clock output, single-wire, smart-card and infrared line handling.
  Assumes inputs synchronous to CLK and a master on the plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
module usmt_top #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX_I,
  input wire logic TX_I,
  output logic TX_O,
  output logic TX_OE,
  input wire logic CTS_N,
  output logic SERIAL_CLOCK_PIN,
  output logic DMA_TX_REQ,
  output logic DMA_RX_REQ,
  output logic IRQ
);
  import usmt_pkg::*;

  typedef struct packed {
    logic [15:0] baud;
    logic [13:0] ctrl1;
    logic [14:0] ctrl2;
    logic [10:0] ctrl3;
    logic [15:0] guard;
    logic [9:0] stat;
    logic stat_rd;
    logic [31:0] rdata;
    logic [8:0] tdr;
    logic [8:0] rdr;
    logic [16:0] acc;
    usmt_txst_t txs;
    logic [5:0] tx_tk;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic [7:0] tx_gt;
    logic tx_on_q;
    logic tx_word;
    usmt_rxst_t rxs;
    logic [5:0] rx_tk;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic [2:0] votes;
    logic rx_noise;
    logic [3:0] idle_bits;
    logic idle_arm;
    logic [4:0] sc_cnt;
    logic sc_clk;
    logic cts_prev;
    logic line;
    logic pin_o;
    logic pin_oe;
    logic ck;
  } usmt_state_t;

  usmt_state_t s_q, s_d;
  logic tick;
  logic [16:0] acc_sum;
  logic rx_in;
  logic [3:0] wlen;
  logic [3:0] frame_len;
  logic [5:0] stop_tk;
  logic tx_par;
  logic rx_bitv;
  logic [8:0] rx_word;
  logic open_drain;
  logic wr_data;

  // refuse an address port too narrow for the map
  generate
    if (ADDR_W < 8)
    begin : g_addr_check
      $error("usmt_top: ADDR_W must be at least 8");
    end
  endgenerate

  // handshake outputs stay combinational
  assign DMA_TX_REQ = s_q.ctrl3[C3_DMA_TX] & s_q.stat[ST_TXEMPTY];
  assign DMA_RX_REQ = s_q.ctrl3[C3_DMA_RX] & s_q.stat[ST_RXFULL];
  assign IRQ = (s_q.stat[ST_TXEMPTY] & s_q.ctrl1[C1_TXEMPTY_IRQ])
             | (s_q.stat[ST_CTS] & s_q.ctrl3[C3_CTS_IRQ])
             | (s_q.stat[ST_TXDONE] & s_q.ctrl1[C1_TXDONE_IRQ])
             | ((s_q.stat[ST_RXFULL] | s_q.stat[ST_OVERRUN]) & s_q.ctrl1[C1_RX_IRQ])
             | (s_q.stat[ST_IDLE] & s_q.ctrl1[C1_IDLE_IRQ])
             | (s_q.stat[ST_PARITY] & s_q.ctrl1[C1_PARITY_IRQ])
             | (s_q.stat[ST_BREAK] & s_q.ctrl2[C2_BREAK_IRQ])
             | (s_q.ctrl3[C3_ERROR_IRQ] & s_q.ctrl3[C3_DMA_RX]
                & (s_q.stat[ST_NOISE] | s_q.stat[ST_OVERRUN] | s_q.stat[ST_FRAMING]));
  // data outputs straight from flip-flops
  assign RDATA = s_q.rdata;
  assign TX_O = s_q.pin_o;
  assign TX_OE = s_q.pin_oe;
  assign SERIAL_CLOCK_PIN = s_q.ck;

  // next-state logic; bus clears are applied before engine sets so sets win
  always_comb
  begin
    s_d = s_q;
    wr_data = WR && (ADDR[7:0] == OFS_DATA);
    open_drain = s_q.ctrl3[C3_SINGLE_WIRE] | s_q.ctrl3[C3_SMARTCARD];
    wlen = s_q.ctrl1[C1_NINE_BITS] ? WORD_9 : WORD_8;
    frame_len = s_q.ctrl1[C1_NINE_BITS] ? IDLE_FRAME_9 : IDLE_FRAME_8;
    case ({s_q.ctrl2[C2_STOP_HI], s_q.ctrl2[C2_STOP_LO]})
      2'h1: stop_tk = STOP_TK_HALF;
      2'h2: stop_tk = STOP_TK_2;
      2'h3: stop_tk = STOP_TK_ONEHALF;
      default: stop_tk = STOP_TK_1;
    endcase
    // single-wire and smart-card listen on the transmit pin
    if (open_drain)
      rx_in = TX_I;
    else
      rx_in = RX_I;
    if (s_q.ctrl3[C3_INFRARED] && (s_q.txs != TXS_IDLE))
      rx_in = 1'b1;
    // fractional divisor: step of sixteen against 16*int+frac
    acc_sum = s_q.acc + ACC_STEP;
    tick = (s_q.baud != 16'h0000) && (acc_sum >= {1'b0, s_q.baud});
    if (tick)
      s_d.acc = acc_sum - {1'b0, s_q.baud};
    else if (s_q.baud == 16'h0000)
      s_d.acc = 17'h00000;
    else
      s_d.acc = acc_sum;
    tx_par = (s_q.ctrl1[C1_NINE_BITS] ? (^s_q.tdr[7:0]) : (^s_q.tdr[6:0]))
             ^ s_q.ctrl1[C1_ODD_PARITY];
    rx_bitv = (s_q.votes[0] & s_q.votes[1]) | (s_q.votes[1] & s_q.votes[2])
              | (s_q.votes[0] & s_q.votes[2]);
    rx_word = s_q.ctrl1[C1_NINE_BITS] ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};

    // register port
    if (WR)
    begin
      case (ADDR[7:0])
        OFS_STATUS:
        begin
          // write-zero clears on the software-cleared flags
          s_d.stat[ST_TXDONE] = s_q.stat[ST_TXDONE] & WDATA[ST_TXDONE];
          s_d.stat[ST_RXFULL] = s_q.stat[ST_RXFULL] & WDATA[ST_RXFULL];
          s_d.stat[ST_BREAK] = s_q.stat[ST_BREAK] & WDATA[ST_BREAK];
          s_d.stat[ST_CTS] = s_q.stat[ST_CTS] & WDATA[ST_CTS];
        end
        OFS_DATA:
        begin
          s_d.tdr = WDATA[8:0];
          s_d.stat[ST_TXEMPTY] = 1'b0;
          if (s_q.stat_rd)
            s_d.stat[ST_TXDONE] = 1'b0;
        end
        OFS_BAUD: s_d.baud = WDATA[15:0];
        OFS_CTRL1: s_d.ctrl1 = WDATA[13:0];
        OFS_CTRL2:
        begin
          // clock shape bits are frozen while either direction is on
          if (!s_q.ctrl1[C1_TRANSMITTER_ON] && !s_q.ctrl1[C1_RECEIVER_ON])
            s_d.ctrl2 = WDATA[14:0];
          else
            s_d.ctrl2 = {WDATA[14:11], s_q.ctrl2[10:8], WDATA[7:0]};
        end
        OFS_CTRL3: s_d.ctrl3 = WDATA[10:0];
        OFS_GUARD: s_d.guard = WDATA[15:0];
        default: s_d.stat_rd = s_q.stat_rd;
      endcase
    end
    if (RD)
    begin
      case (ADDR[7:0])
        OFS_STATUS: s_d.rdata = {22'h000000, s_q.stat};
        OFS_DATA: s_d.rdata = {23'h000000, s_q.rdr};
        OFS_BAUD: s_d.rdata = {16'h0000, s_q.baud};
        OFS_CTRL1: s_d.rdata = {18'h00000, s_q.ctrl1};
        OFS_CTRL2: s_d.rdata = {17'h00000, s_q.ctrl2};
        OFS_CTRL3: s_d.rdata = {21'h000000, s_q.ctrl3};
        OFS_GUARD: s_d.rdata = {16'h0000, s_q.guard};
        default: s_d.rdata = 32'h00000000;
      endcase
      if (ADDR[7:0] == OFS_STATUS)
        s_d.stat_rd = 1'b1;
      if (ADDR[7:0] == OFS_DATA)
      begin
        s_d.stat[ST_RXFULL] = 1'b0;
        s_d.stat_rd = 1'b0;
        if (s_q.stat_rd)
        begin
          // status-then-data read sequence clears the error group
          s_d.stat[ST_PARITY] = 1'b0;
          s_d.stat[ST_FRAMING] = 1'b0;
          s_d.stat[ST_NOISE] = 1'b0;
          s_d.stat[ST_OVERRUN] = 1'b0;
          s_d.stat[ST_IDLE] = 1'b0;
        end
      end
    end

    // clear-to-send change detect
    s_d.cts_prev = CTS_N;
    if (s_q.ctrl3[C3_CTS_EN] && (CTS_N != s_q.cts_prev))
      s_d.stat[ST_CTS] = 1'b1;

    // smart-card clock: toggles every prescaler clocks, period twice that
    if (s_q.ctrl3[C3_SMARTCARD] && (s_q.guard[GP_PRESC_HI:GP_PRESC_LO] != 5'h00))
    begin
      if (s_q.sc_cnt + 5'h01 >= s_q.guard[GP_PRESC_HI:GP_PRESC_LO])
      begin
        s_d.sc_cnt = 5'h00;
        s_d.sc_clk = ~s_q.sc_clk;
      end
      else
        s_d.sc_cnt = s_q.sc_cnt + 5'h01;
    end
    else
    begin
      s_d.sc_cnt = 5'h00;
      s_d.sc_clk = 1'b0;
    end

    // transmitter, advanced once per oversampling tick
    if (!s_q.ctrl1[C1_ENABLE] || !s_q.ctrl1[C1_TRANSMITTER_ON])
    begin
      s_d.txs = TXS_IDLE;
      s_d.tx_on_q = 1'b0;
      s_d.line = 1'b1;
    end
    else if (tick)
    begin
      s_d.tx_tk = s_q.tx_tk + 6'h01;
      case (s_q.txs)
        TXS_IDLE:
        begin
          s_d.tx_tk = 6'h00;
          s_d.tx_bit = 4'h0;
          s_d.line = 1'b1;
          s_d.tx_on_q = 1'b1;
          if (!s_q.tx_on_q)
            s_d.txs = TXS_PREAMBLE;
          else if (s_q.ctrl1[C1_SEND_BREAK])
          begin
            s_d.txs = TXS_BREAK;
            s_d.line = 1'b0;
          end
          else if (!s_q.stat[ST_TXEMPTY] && !wr_data)
          begin
            // word goes to the shifter at once, also in single-wire mode
            s_d.tx_sh = s_q.tdr;
            if (s_q.ctrl1[C1_PARITY_ON])
            begin
              if (s_q.ctrl1[C1_NINE_BITS])
                s_d.tx_sh[8] = tx_par;
              else
                s_d.tx_sh[7] = tx_par;
            end
            s_d.stat[ST_TXEMPTY] = 1'b1;
            s_d.tx_word = 1'b1;
            s_d.txs = TXS_START;
            s_d.line = 1'b0;
          end
        end
        TXS_PREAMBLE, TXS_BREAK:
        begin
          if (s_q.tx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.tx_tk = 6'h00;
            s_d.tx_bit = s_q.tx_bit + 4'h1;
            if (s_q.tx_bit + 4'h1 == frame_len)
            begin
              s_d.line = 1'b1;
              s_d.tx_bit = 4'h0;
              s_d.tx_word = 1'b0;
              if (s_q.txs == TXS_BREAK)
              begin
                s_d.ctrl1[C1_SEND_BREAK] = 1'b0;
                s_d.txs = TXS_STOP;
              end
              else
                s_d.txs = TXS_IDLE;
            end
          end
        end
        TXS_START:
        begin
          if (s_q.tx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.tx_tk = 6'h00;
            s_d.txs = TXS_DATA;
            s_d.line = s_q.tx_sh[0];
          end
        end
        TXS_DATA:
        begin
          if (s_q.tx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.tx_tk = 6'h00;
            s_d.tx_bit = s_q.tx_bit + 4'h1;
            if (s_q.tx_bit + 4'h1 == wlen)
            begin
              s_d.txs = TXS_STOP;
              s_d.line = 1'b1;
            end
            else
              s_d.line = s_q.tx_sh[s_q.tx_bit + 4'h1];
          end
        end
        TXS_STOP:
        begin
          // card pulls the line mid stop bit to refuse the frame
          if (s_q.ctrl3[C3_SMARTCARD] && (s_q.tx_tk == TICK_MID) && !TX_I)
            s_d.stat[ST_FRAMING] = 1'b1;
          if (s_q.tx_tk == stop_tk - 6'h01)
          begin
            s_d.tx_tk = 6'h00;
            s_d.tx_gt = 8'h00;
            if (s_q.ctrl3[C3_SMARTCARD] && (s_q.guard[GP_GUARD_HI:GP_GUARD_LO] != 8'h00))
              s_d.txs = TXS_GUARD;
            else
            begin
              s_d.txs = TXS_IDLE;
              if (s_q.tx_word && s_q.stat[ST_TXEMPTY])
                s_d.stat[ST_TXDONE] = 1'b1;
            end
          end
        end
        TXS_GUARD:
        begin
          if (s_q.tx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.tx_tk = 6'h00;
            s_d.tx_gt = s_q.tx_gt + 8'h01;
            if (s_q.tx_gt + 8'h01 == s_q.guard[GP_GUARD_HI:GP_GUARD_LO])
            begin
              s_d.txs = TXS_IDLE;
              if (s_q.stat[ST_TXEMPTY])
                s_d.stat[ST_TXDONE] = 1'b1;
            end
          end
        end
        default: s_d.txs = TXS_IDLE;
      endcase
    end

    // receiver, sampling at sixteen times the bit rate
    if (!s_q.ctrl1[C1_ENABLE] || !s_q.ctrl1[C1_RECEIVER_ON])
      s_d.rxs = RXS_IDLE;
    else if (tick)
    begin
      s_d.rx_tk = s_q.rx_tk + 6'h01;
      if ((s_q.rx_tk == TICK_MID - 6'h01) || (s_q.rx_tk == TICK_MID)
          || (s_q.rx_tk == TICK_MID + 6'h01))
        s_d.votes = {s_q.votes[1:0], rx_in};
      case (s_q.rxs)
        RXS_IDLE:
        begin
          s_d.rx_tk = 6'h00;
          s_d.rx_bit = 4'h0;
          if (!rx_in)
          begin
            s_d.rxs = RXS_START;
            s_d.rx_noise = 1'b0;
            s_d.idle_bits = 4'h0;
          end
          else if (s_q.idle_arm && (s_q.rx_tk == 6'h00))
          begin
            // idle counts whole quiet frames, once per received word
            s_d.rx_tk = 6'h01;
          end
          else if (s_q.idle_arm && (s_q.rx_tk == TICKS_BIT - 6'h01))
          begin
            s_d.idle_bits = s_q.idle_bits + 4'h1;
            if (s_q.idle_bits + 4'h1 == frame_len)
            begin
              s_d.stat[ST_IDLE] = 1'b1;
              s_d.idle_arm = 1'b0;
            end
          end
          else if (s_q.idle_arm)
            s_d.rx_tk = s_q.rx_tk + 6'h01;
        end
        RXS_START:
        begin
          if ((s_q.rx_tk == TICK_MID) && rx_in)
            s_d.rxs = RXS_IDLE;
          else if (s_q.rx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.rx_tk = 6'h00;
            s_d.rxs = RXS_DATA;
          end
        end
        RXS_DATA:
        begin
          if (s_q.rx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.rx_tk = 6'h00;
            // infrared receive level is taken as is: high is one
            s_d.rx_sh = {rx_bitv, s_q.rx_sh[8:1]};
            if (s_q.votes != 3'h0 && s_q.votes != 3'h7)
              s_d.rx_noise = 1'b1;
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit + 4'h1 == wlen)
              s_d.rxs = RXS_STOP;
          end
        end
        RXS_STOP:
        begin
          // one tick after the last vote, so all three stop votes are fresh
          if (s_q.rx_tk == TICK_MID + 6'h02)
          begin
            s_d.rx_tk = 6'h00;
            s_d.rxs = RXS_WAITHI;
            s_d.idle_arm = 1'b1;
            if (s_q.stat[ST_RXFULL])
              s_d.stat[ST_OVERRUN] = 1'b1; // keeps the unread word
            else
            begin
              s_d.rdr = rx_word;
              s_d.stat[ST_RXFULL] = 1'b1;
            end
            if (s_q.ctrl1[C1_PARITY_ON] && ((^rx_word) ^ s_q.ctrl1[C1_ODD_PARITY]))
            begin
              s_d.stat[ST_PARITY] = 1'b1;
              if (s_q.ctrl3[C3_SMARTCARD])
                s_d.rxs = RXS_NACK;
            end
            if (!rx_bitv)
            begin
              s_d.stat[ST_FRAMING] = 1'b1;
              if (s_q.ctrl2[C2_LIN_EN] && (rx_word == 9'h000))
                s_d.stat[ST_BREAK] = 1'b1;
            end
            if (s_q.rx_noise || (s_q.votes != 3'h0 && s_q.votes != 3'h7))
              s_d.stat[ST_NOISE] = 1'b1;
          end
        end
        RXS_NACK:
        begin
          if (s_q.rx_tk == TICKS_BIT - 6'h01)
          begin
            s_d.rx_tk = 6'h00;
            s_d.rxs = RXS_WAITHI;
          end
        end
        RXS_WAITHI:
        begin
          // own pull-down is never mistaken for a new start bit
          s_d.rx_tk = 6'h00;
          if (rx_in)
            s_d.rxs = RXS_IDLE;
        end
        default: s_d.rxs = RXS_IDLE;
      endcase
    end

    // transmit pin: open-drain without infrared only ever pulls low
    s_d.pin_o = s_d.line;
    s_d.pin_oe = 1'b1;
    if (s_d.rxs == RXS_NACK)
      s_d.pin_o = 1'b0;
    if (s_q.ctrl3[C3_INFRARED])
    begin
      if (s_q.rxs != RXS_IDLE && s_q.rxs != RXS_WAITHI)
        s_d.pin_o = 1'b0;
      else
        s_d.pin_o = ~s_d.line;
    end
    else if (open_drain)
    begin
      s_d.pin_oe = ~s_d.pin_o;
      s_d.pin_o = 1'b0;
    end

    // clock pin: card clock, or bit clock only across data bits
    s_d.ck = s_q.ctrl2[C2_CLK_POL];
    if (s_q.ctrl3[C3_SMARTCARD] && s_q.ctrl2[C2_SYNC_CLK_EN])
      s_d.ck = s_q.sc_clk;
    else if (s_q.ctrl2[C2_SYNC_CLK_EN] && (s_d.txs == TXS_DATA)
             && (s_q.ctrl2[C2_LAST_BIT_CLK] || (s_d.tx_bit != wlen - 4'h1)))
      s_d.ck = s_q.ctrl2[C2_CLK_POL]
               ^ (s_q.ctrl2[C2_CLK_PHASE] ^ (s_d.tx_tk >= TICK_MID));
  end

  // the whole state registers here; synchronous reset
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
      s_q.stat <= STATUS_RESET;
      s_q.txs <= TXS_IDLE;
      s_q.rxs <= RXS_IDLE;
      s_q.line <= 1'b1;
      s_q.pin_o <= 1'b1;
      s_q.pin_oe <= 1'b1;
      s_q.cts_prev <= 1'b1;
    end
    else
      s_q <= s_d;
  end
endmodule : usmt_top
`default_nettype wire

// file: usmt_top_assertions.sv
/*
  Port checker for usmt_top, bound into every instance.
  Assumes control words are written only while the link is quiet.
*/
`timescale 1ns/1ps
`default_nettype none
module usmt_top_chk
  import usmt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic TX_O,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic DMA_TX_REQ,
  input wire logic DMA_RX_REQ,
  input wire logic IRQ
);
  logic [2:0][31:0] sh_q;
  logic od;
  // shadow of ctrl1..3; locked ctrl2 bits may differ, harmless here
  always_ff @(posedge CLK)
    if (!RST_N)
      sh_q <= '0;
    else if (WR && ADDR[7:0] inside {OFS_CTRL1, OFS_CTRL2, OFS_CTRL3})
      sh_q[2'((ADDR[7:0] - OFS_CTRL1) >> 2)] <= WDATA;
  assign od = sh_q[2][C3_SINGLE_WIRE] | sh_q[2][C3_SMARTCARD];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_rx_read_clears: assert property (RD && ADDR[7:0] == OFS_DATA |=> !DMA_RX_REQ)
    else $error("receive request stayed after data read");
  a_unmapped_zero: assert property (RD && ADDR[7:0] > OFS_GUARD |=> RDATA == '0)
    else $error("unmapped read not zero");
  a_dma_tx_gate: assert property (!sh_q[2][C3_DMA_TX] |-> !DMA_TX_REQ)
    else $error("transmit request while disabled");
  a_dma_rx_gate: assert property (!sh_q[2][C3_DMA_RX] |-> !DMA_RX_REQ)
    else $error("receive request while disabled");
  a_start_bit_low: assert property ($fell(TX_O) && !od && !sh_q[2][C3_INFRARED] |-> !TX_O [*8])
    else $error("start bit too short");
  a_od_no_high: assert property (od && $past(od) |-> !TX_O)
    else $error("open-drain pin driven high");
  a_sync_clk_quiet: assert property (!sh_q[1][C2_SYNC_CLK_EN] && !sh_q[2][C3_SMARTCARD]
    && $stable(sh_q) |=> $stable(SERIAL_CLOCK_PIN))
    else $error("clock pin moved while off");
  a_irq_masked: assert property (sh_q[0][8:4] == '0 && !sh_q[1][C2_BREAK_IRQ]
    && !sh_q[2][C3_ERROR_IRQ] && !sh_q[2][C3_CTS_IRQ] |-> !IRQ)
    else $error("interrupt with all sources masked");
  c_rx_ready: cover property (DMA_RX_REQ);
  c_irq: cover property (IRQ);
  c_start: cover property ($fell(TX_O));
endmodule : usmt_top_chk
bind usmt_top usmt_top_chk #(.ADDR_W(ADDR_W)) chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_O(TX_O),
  .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .DMA_TX_REQ(DMA_TX_REQ), .DMA_RX_REQ(DMA_RX_REQ),
  .IRQ(IRQ));
`default_nettype wire

// file: usmt_node.sv
/*
  Far serial node: decodes frames on the line, sends frames to the receiver.
  Assumes eight data bits, no parity, a fixed clock count per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module usmt_node #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic rx_line
);
  logic [8:0] got = '0;
  int got_n = 0;
  initial rx_line = 1'b1; // idle line rests high
  // mid-bit samples: eight data bits lsb first, then stop level in got[8]
  always
  begin
    @(negedge line);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge clk);
      got[i] = line;
    end
    got_n++;
  end
  // start low, lsb first, one stop bit
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++)
    begin
      rx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (BIT) @(posedge clk);
    end
  endtask : send
endmodule : usmt_node
`default_nettype wire

// file: usmt_top_test.sv
/*
  Self-checking bench for usmt_top with a serial node on the line.
  Assumes baud 0x0010, so one bit lasts sixteen clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) check(n, 32'(e), 32'(s))
module usmt_top_test;
  import usmt_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} usmt_row_t;
  logic CLK, RX_I, TX_O, TX_OE, SCK, DTX, DRX, IRQ, tx_pin;
  logic RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0] ADDR = '0;
  logic [31:0] WDATA = '0, RDATA, q;
  int bad_count = 0, checks = 0, n, k, m = 0;
  usmt_row_t rows [6] = '{
    '{1'b0, OFS_STATUS, 32'h0, 32'h0C0},
    '{1'b1, OFS_BAUD, 32'h10, 32'h10},
    '{1'b1, OFS_GUARD, 32'hFFFFFFFF, 32'hFFFF},
    '{1'b1, 8'h1C, 32'hFFFFFFFF, 32'h0},
    '{1'b1, OFS_CTRL3, 32'hC0, 32'hC0},
    '{1'b1, OFS_CTRL2, 32'h3000, 32'h3000}};
  assign tx_pin = TX_OE ? TX_O : 1'b1; // pull-up on the line
  usmt_top dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX_I(RX_I), .TX_I(tx_pin), .TX_O(TX_O), .TX_OE(TX_OE), .CTS_N(1'b1),
    .SERIAL_CLOCK_PIN(SCK), .DMA_TX_REQ(DTX), .DMA_RX_REQ(DRX), .IRQ(IRQ));
  usmt_node #(.BIT(16)) node (.clk(CLK), .line(tx_pin), .rx_line(RX_I));
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    // one quiet edge, so a following write never sets WR in this step
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  // read data holds until the next read, so take it one edge late
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    r = RDATA;
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      `CHK($sformatf("reg %h", rows[i].a), rows[i].e, q);
    end
    `CHK("dma tx", 1, DTX);
    wr(OFS_CTRL1, 32'h202C);
    wr(OFS_DATA, 32'hA5);
    @(posedge CLK);
    `CHK("tx empty", 0, DTX);
    for (n = 0; tx_pin && n < 400; n++) @(posedge CLK);
    `CHK("idle frame", 1, n >= 150 && n <= 185);
    for (n = 0; node.got_n < 1 && n < 400; n++) @(posedge CLK);
    `CHK("tx frame", 9'h1A5, node.got);
    `CHK("dma refill", 1, DTX);
    node.send(8'h3C);
    for (n = 0; !DRX && n < 100; n++) @(posedge CLK);
    `CHK("rx request", 1, DRX);
    `CHK("rx irq", 1, IRQ);
    wr(OFS_CTRL1, 32'h200C);
    @(posedge CLK);
    `CHK("irq masked", 0, IRQ);
    rd(OFS_DATA, q);
    `CHK("rx data", 8'h3C, q);
    `CHK("rx cleared", 0, DRX);
    wr(OFS_CTRL2, 32'h3700);
    rd(OFS_CTRL2, q);
    `CHK("ctrl2 locked", 32'h3000, q);
    wr(OFS_CTRL3, 32'hC8);
    repeat (3) @(posedge CLK);
    `CHK("open drain", 0, TX_O);
    `CHK("od released", 0, TX_OE);
    wr(OFS_CTRL2, 32'h0);
    wr(OFS_CTRL3, 32'hC2);
    repeat (3) @(posedge CLK);
    `CHK("ir idle", 0, TX_O);
    // synchronous mode: clock shape set only while both directions are off
    wr(OFS_CTRL1, 32'h2000);
    wr(OFS_CTRL3, 32'h0);
    wr(OFS_CTRL2, 32'h800);
    wr(OFS_CTRL1, 32'h2008);
    wr(OFS_DATA, 32'h55);
    for (n = 0; n < 400; n++)
    begin
      k = SCK;
      @(posedge CLK);
      if (SCK && !k)
        m++;
    end
    `CHK("sync clocks", 7, m);
    `CHK("sync frame", 9'h155, node.got);
    // card clock: prescaler 0x1F gives one period of 62 clocks
    wr(OFS_CTRL2, 32'h3800);
    wr(OFS_CTRL1, 32'h2408);
    wr(OFS_CTRL3, 32'h20);
    for (n = 0; !SCK && n < 100; n++) @(posedge CLK);
    for (n = 0; SCK && n < 100; n++) @(posedge CLK);
    for (k = 0; !SCK && k < 100; k++) @(posedge CLK);
    `CHK("card clock", 62, n + k);
    // mid-run reset must stop the card clock and drive the pin again
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    `CHK("reset oe", 1, TX_OE);
    `CHK("reset clock", 0, SCK);
    rd(OFS_STATUS, q);
    `CHK("reset status", 32'h0C0, q);
    close_out();
  end
  // watchdog well beyond the roughly one thousand cycles the run needs
  initial
  begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    close_out();
  end
endmodule : usmt_top_test
`default_nettype wire
